// >>> logic/fia_flash_access.sv
// The register offsets and the APB interface to the registers were left to the implementer.
module fia_flash_access
  import fia_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // factory options
  input  wire logic [2:0]             opt_loader_pages,
  input  wire logic [PAGE_NUM_W-1:0]  data_region_floor,
  // cpu side
  input  wire logic                   exec_in_loader,
  output logic                        cpu_stall,
  output logic                        irq_hold,
  // flash array
  output logic                        fl_req,
  output fia_op_type                  fl_cmd,
  output logic [ADDR_W-1:0]           fl_addr,
  output logic [7:0]                  fl_wdata,
  input  wire logic                   fl_ack,
  input  wire logic [7:0]             fl_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 en;
    logic [SCALE_W-1:0]   scale;
    fia_op_type           op;
    logic [ADDR_HI_W-1:0] ahi;
    logic [7:0]           alo;
    logic [7:0]           data;
    logic                 busy;
    logic                 start;
    logic                 refused;
    logic [31:0]          prdata;
    logic                 slverr;
  } fia_top_type;

  fia_top_type s_r;
  fia_top_type s_nxt;

  fia_seq_if seq ();

  logic              key_wr;
  logic              key_ok;
  logic [ADDR_W-1:0] tgt_addr;
  logic [ADDR_W-1:0] loader_start;
  logic [ADDR_W-1:0] floor_addr;
  logic              in_range;
  logic              may_modify;
  logic              go;
  logic              setup_ph;
  logic              access_ph;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = reg_hit(a, REG_CTRL) || reg_hit(a, REG_OPSEL) ||
             reg_hit(a, REG_ADDR_HI) || reg_hit(a, REG_ADDR_LO) ||
             reg_hit(a, REG_DATA) || reg_hit(a, REG_KEY) || reg_hit(a, REG_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // region map: one array shared by all three regions
  // ----------------------------------------------------------------
  assign tgt_addr     = {s_r.ahi, s_r.alo};
  assign loader_start = FLASH_END -
                        ADDR_W'({opt_loader_pages, PAGE_ZERO});
  assign floor_addr   = {data_region_floor, PAGE_ZERO};
  assign in_range     = (tgt_addr < loader_start);
  // loader code may touch everything below itself, application code
  // only the data region
  assign may_modify   = exec_in_loader ? 1'b1 : (tgt_addr >= floor_addr);

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign key_wr    = access_ph && pwrite && reg_hit(paddr, REG_KEY);

  fia_key_unlock u_key (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (key_wr),
    .key_byte (pwdata[7:0]),
    .enable   (s_r.en),
    .key_ok   (key_ok)
  );

  // ----------------------------------------------------------------
  // trigger qualification
  // ----------------------------------------------------------------
  always_comb begin
    go = 1'b0;
    if (key_ok && !s_r.busy && s_r.op != OP_STANDBY && in_range) begin
      go = (s_r.op == OP_READ) ? 1'b1 : may_modify;
    end
  end

  // ----------------------------------------------------------------
  // register file and control
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    if (access_ph && pwrite && !s_r.busy) begin
      if (reg_hit(paddr, REG_CTRL)) begin
        s_nxt.en    = pwdata[CTRL_EN_BIT];
        s_nxt.scale = pwdata[SCALE_W-1:0];
      end
      if (reg_hit(paddr, REG_OPSEL)) begin
        s_nxt.op = fia_op_type'(pwdata[1:0]);
      end
      if (reg_hit(paddr, REG_ADDR_HI)) begin
        s_nxt.ahi = pwdata[ADDR_HI_W-1:0];
      end
      if (reg_hit(paddr, REG_ADDR_LO)) begin
        s_nxt.alo = pwdata[7:0];
      end
      if (reg_hit(paddr, REG_DATA)) begin
        s_nxt.data = pwdata[7:0];
      end
      if (reg_hit(paddr, REG_STATUS) && pwdata[STAT_REFUS_BIT]) begin
        s_nxt.refused = 1'b0;
      end
    end
    // a refused trigger raises the flag; set wins over the clear
    if (key_ok && !go) begin
      s_nxt.refused = 1'b1;
    end
    if (go) begin
      s_nxt.busy  = 1'b1;
      s_nxt.start = 1'b1;
    end
    if (seq.done) begin
      s_nxt.busy = 1'b0;
      if (s_r.op == OP_READ) begin
        s_nxt.data = seq.rdata;
      end
    end
    if (setup_ph) begin
      s_nxt.slverr = !mapped(paddr);
      s_nxt.prdata = WORD_ZERO;
      if (reg_hit(paddr, REG_CTRL)) begin
        s_nxt.prdata[CTRL_EN_BIT]   = s_r.en;
        s_nxt.prdata[SCALE_W-1:0]   = s_r.scale;
      end
      if (reg_hit(paddr, REG_OPSEL)) begin
        s_nxt.prdata[1:0] = s_r.op;
      end
      if (reg_hit(paddr, REG_ADDR_HI)) begin
        s_nxt.prdata[ADDR_HI_W-1:0] = s_r.ahi;
      end
      if (reg_hit(paddr, REG_ADDR_LO)) begin
        s_nxt.prdata[7:0] = s_r.alo;
      end
      if (reg_hit(paddr, REG_DATA)) begin
        s_nxt.prdata[7:0] = s_r.data;
      end
      if (reg_hit(paddr, REG_STATUS)) begin
        s_nxt.prdata[STAT_BUSY_BIT]  = s_r.busy;
        s_nxt.prdata[STAT_REFUS_BIT] = s_r.refused;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // sequencer hookup
  // ----------------------------------------------------------------
  assign seq.start = s_r.start;
  assign seq.op    = s_r.op;
  assign seq.addr  = tgt_addr;
  assign seq.wdata = s_r.data;
  assign seq.scale = s_r.scale;

  fia_flash_seq u_seq (
    .pclk     (pclk),
    .presetn  (presetn),
    .seq      (seq),
    .fl_req   (fl_req),
    .fl_cmd   (fl_cmd),
    .fl_addr  (fl_addr),
    .fl_wdata (fl_wdata),
    .fl_ack   (fl_ack),
    .fl_rdata (fl_rdata)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the stall covers the key acceptance cycle too, so the cpu never
  // runs ahead of the operation it just launched
  assign cpu_stall = go || s_r.busy;
  assign irq_hold  = cpu_stall;
  assign prdata    = s_r.prdata;
  assign pready    = 1'b1;
  assign pslverr   = s_r.slverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_standby_no_start: assert property (@(posedge pclk) disable iff (!presetn)
    (key_ok && s_r.op == OP_STANDBY) |=> !s_r.busy)
    else $error("standby trigger started an operation");

  a_range_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (key_ok && !in_range) |=> (!s_r.busy && s_r.refused))
    else $error("out of range trigger was not refused");

  a_app_data_only: assert property (@(posedge pclk) disable iff (!presetn)
    (key_ok && !exec_in_loader && s_r.op == OP_PROGRAM && tgt_addr < floor_addr)
      |=> !s_r.busy)
    else $error("application code modified outside data region");

  a_loader_app_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (key_ok && !s_r.busy && exec_in_loader && s_r.op == OP_ERASE && in_range)
      |=> s_r.busy)
    else $error("loader erase of application region refused");

  a_stall_until_done: assert property (@(posedge pclk) disable iff (!presetn)
    (go || (s_r.busy && !seq.done)) |=> s_r.busy)
    else $error("cpu released before operation done");

  a_done_releases: assert property (@(posedge pclk) disable iff (!presetn)
    seq.done |=> !s_r.busy)
    else $error("cpu still stalled after operation done");

  a_read_lands_data: assert property (@(posedge pclk) disable iff (!presetn)
    (seq.done && s_r.op == OP_READ) |=> (s_r.data == $past(seq.rdata)))
    else $error("read byte not placed in data register");

  a_disabled_no_go: assert property (@(posedge pclk) disable iff (!presetn)
    !s_r.en |-> !go)
    else $error("operation started while disabled");

  a_app_data_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (key_ok && !s_r.busy && !exec_in_loader && s_r.op == OP_PROGRAM && in_range &&
      tgt_addr >= floor_addr) |=> s_r.busy)
    else $error("application write to data region refused");

  a_read_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    (key_ok && !s_r.busy && s_r.op == OP_READ && in_range) |=> s_r.busy)
    else $error("in range read refused");

  // ----------------------------------------------------------------
  // array-side checks; the window covers the slowest clock scale
  // ----------------------------------------------------------------
  a_target_reaches_array: assert property (@(posedge pclk) disable iff (!presetn)
    (go && s_r.op != OP_ERASE) |-> ##[3:40] (fl_req && fl_addr == tgt_addr))
    else $error("array cycle not at target address");

  a_erase_reaches_array: assert property (@(posedge pclk) disable iff (!presetn)
    (go && s_r.op == OP_ERASE) |-> ##[3:40]
      (fl_req && fl_cmd == OP_ERASE && fl_addr == {tgt_addr[ADDR_W-1:PAGE_BITS], PAGE_ZERO}))
    else $error("page erase not sent to page base");

endmodule : fia_flash_access

// >>> logic/fia_flash_seq.sv
module fia_flash_seq
  import fia_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request from control
  fia_seq_if.eng                 seq,
  // flash array port
  output logic                   fl_req,
  output fia_op_type             fl_cmd,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [7:0]             fl_wdata,
  input  wire logic              fl_ack,
  input  wire logic [7:0]        fl_rdata
);

  typedef struct packed {
    fia_seq_state_type  st;
    logic [SCALE_W-1:0] cnt;
    fia_op_type         op;
    fia_op_type         cmd;
    logic               req;
    logic [ADDR_W-1:0]  addr;
    logic [7:0]         wdata;
    logic [7:0]         fwdata;
    logic               done;
    logic [7:0]         rdata;
  } fia_sq_type;

  fia_sq_type s_r;
  fia_sq_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      SQ_IDLE: begin
        if (seq.start) begin
          s_nxt.st    = SQ_WAIT;
          s_nxt.cnt   = seq.scale;
          s_nxt.op    = seq.op;
          s_nxt.wdata = seq.wdata;
          // erase works on the whole page, low bits forced clear
          s_nxt.addr  = (seq.op == OP_ERASE) ?
                        {seq.addr[ADDR_W-1:PAGE_BITS], PAGE_ZERO} : seq.addr;
          // program first reads the old byte so bits can only fall
          s_nxt.cmd   = (seq.op == OP_PROGRAM) ? OP_READ : seq.op;
        end
      end
      SQ_WAIT: begin
        // scaled delay before each array cycle
        if (s_r.cnt == '0) begin
          s_nxt.req = 1'b1;
          s_nxt.st  = SQ_ACCESS;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      SQ_ACCESS: begin
        if (fl_ack) begin
          s_nxt.req = 1'b0;
          if (s_r.op == OP_PROGRAM && s_r.cmd == OP_READ) begin
            s_nxt.fwdata = fl_rdata & s_r.wdata;
            s_nxt.cmd    = OP_PROGRAM;
            s_nxt.cnt    = seq.scale;
            s_nxt.st     = SQ_WAIT;
          end else begin
            s_nxt.rdata = fl_rdata;
            s_nxt.done  = 1'b1;
            s_nxt.st    = SQ_IDLE;
          end
        end
      end
      default: s_nxt.st = SQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fl_req     = s_r.req;
  assign fl_cmd     = s_r.cmd;
  assign fl_addr    = s_r.addr;
  assign fl_wdata   = s_r.fwdata;
  assign seq.done   = s_r.done;
  assign seq.rdata  = s_r.rdata;

  a_prog_only_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (fl_req && fl_cmd == OP_PROGRAM) |-> ((fl_wdata & ~s_r.wdata) == BYTE_ZERO))
    else $error("program would raise a bit");

  a_erase_page_base: assert property (@(posedge pclk) disable iff (!presetn)
    (fl_req && fl_cmd == OP_ERASE) |-> (fl_addr[PAGE_BITS-1:0] == PAGE_ZERO))
    else $error("erase address not page aligned");

endmodule : fia_flash_seq

// >>> logic/fia_key_unlock.sv
module fia_key_unlock
  import fia_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // key port writes
  input  wire logic       key_wr,
  input  wire logic [7:0] key_byte,
  input  wire logic       enable,
  // result
  output logic            key_ok
);

  typedef struct packed {
    logic armed;
  } fia_key_state_type;

  fia_key_state_type s_r;
  fia_key_state_type s_nxt;

  always_comb begin
    s_nxt  = s_r;
    key_ok = 1'b0;
    if (!enable) begin
      s_nxt.armed = 1'b0;
    end else if (key_wr) begin
      key_ok      = s_r.armed && (key_byte == KEY_SECOND);
      s_nxt.armed = (key_byte == KEY_FIRST);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  a_key_needs_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.armed) |-> $past(key_wr && key_byte == KEY_FIRST && enable))
    else $error("key armed without first key byte before");

  a_enable_disarms: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> !s_r.armed)
    else $error("key stayed armed while disabled");

endmodule : fia_key_unlock

// >>> logic/fia_pkg.sv
package fia_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the apb bus, one 32-bit word apart)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_OPSEL    = 8'h04;
  localparam logic [7:0] REG_ADDR_HI  = 8'h08;
  localparam logic [7:0] REG_ADDR_LO  = 8'h0c;
  localparam logic [7:0] REG_DATA     = 8'h10;
  localparam logic [7:0] REG_KEY      = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 7;
  localparam int SCALE_W        = 5;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_REFUS_BIT = 1;
  localparam int ADDR_W         = 14;
  localparam int ADDR_HI_W      = 6;
  localparam int PAGE_BITS      = 9;
  localparam int PAGE_NUM_W     = 5;

  // ----------------------------------------------------------------
  // codes and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST   = 8'h46;
  localparam logic [7:0] KEY_SECOND  = 8'hb9;
  localparam logic [ADDR_W-1:0] FLASH_END = 14'h3e00;
  localparam logic [PAGE_BITS-1:0] PAGE_ZERO = 9'h000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_STANDBY,
    OP_READ,
    OP_PROGRAM,
    OP_ERASE
  } fia_op_type;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_WAIT,
    SQ_ACCESS
  } fia_seq_state_type;

endpackage : fia_pkg

// >>> logic/fia_seq_if.sv
interface fia_seq_if;
  import fia_pkg::*;
  logic                      start;
  fia_op_type                op;
  logic [ADDR_W-1:0]         addr;
  logic [7:0]                wdata;
  logic [SCALE_W-1:0]        scale;
  logic                      done;
  logic [7:0]                rdata;

  modport ctrl (output start, op, addr, wdata, scale, input done, rdata);
  modport eng  (input start, op, addr, wdata, scale, output done, rdata);
endinterface : fia_seq_if

// >>> verif/fia_flash_model.sv
module fia_flash_model
  import fia_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // array port
  input  wire logic        fl_req,
  input  wire fia_op_type  fl_cmd,
  input  wire logic [13:0] fl_addr,
  input  wire logic [7:0]  fl_wdata,
  output logic             fl_ack,
  output logic [7:0]       fl_rdata,
  // pacing
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [0:16383];
  logic [2:0] wait_cnt;

  // ----------------------------------------------------------------
  // one array shared by every region, cycle answered after a delay
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_ack   <= 1'b0;
      fl_rdata <= 8'h00;
      wait_cnt <= 3'h0;
      for (int i = 0; i < 16384; i++) begin
        mem[i] <= 8'(i) ^ 8'h3c;
      end
    end else begin
      fl_ack   <= 1'b0;
      // data lines are not held outside the answer cycle
      fl_rdata <= ~fl_rdata;
      if (fl_req && !fl_ack) begin
        if (wait_cnt == (slow ? 3'h4 : 3'h0)) begin
          wait_cnt <= 3'h0;
          fl_ack   <= 1'b1;
          case (fl_cmd)
            OP_READ:    fl_rdata <= mem[fl_addr];
            OP_PROGRAM: mem[fl_addr] <= mem[fl_addr] & fl_wdata;
            OP_ERASE: begin
              for (int i = 0; i < 512; i++) begin
                mem[{fl_addr[13:9], 9'(i)}] <= 8'hff;
              end
            end
            default: ;
          endcase
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule // fia_flash_model

// >>> verif/tb_top.sv
module tb_top
  import fia_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [32:0] val;
    string       what;
  } fia_exp_type;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, fl_wdata, fl_rdata;
  logic [31:0] pwdata, prdata, seed;
  logic [2:0]  opt_loader_pages;
  logic [4:0]  data_region_floor;
  logic        exec_in_loader, cpu_stall, irq_hold, fl_req, fl_ack, slow;
  fia_op_type  fl_cmd;
  logic [13:0] fl_addr;
  logic [7:0]  pg [0:511];
  fia_exp_type exp_q [$];
  int          n_fail, samples_checked, n_acc;

  fia_flash_access uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opt_loader_pages(opt_loader_pages),
    .data_region_floor(data_region_floor), .exec_in_loader(exec_in_loader),
    .cpu_stall(cpu_stall), .irq_hold(irq_hold), .fl_req(fl_req), .fl_cmd(fl_cmd),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata));

  fia_flash_model u_flash (.pclk(pclk), .presetn(presetn), .fl_req(fl_req),
    .fl_cmd(fl_cmd), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack),
    .fl_rdata(fl_rdata), .slow(slow));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one idle edge after each transfer keeps psel from being driven twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic apb_rd(input logic [7:0] a, input logic [32:0] e, input string what);
    exp_q.push_back('{e, what});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic keys(input logic [7:0] b1, input logic [7:0] b2);
    apb(1'b1, REG_KEY, {24'h00_0000, b1});
    apb(1'b1, REG_KEY, {24'h00_0000, b2});
  endtask

  task automatic op(input fia_op_type c, input logic [13:0] a, input logic [7:0] d,
                    input logic ok);
    int n0;
    int k;
    apb(1'b1, REG_OPSEL, {30'h0, c});
    apb(1'b1, REG_ADDR_HI, {26'h0, a[13:8]});
    apb(1'b1, REG_ADDR_LO, {24'h00_0000, a[7:0]});
    apb(1'b1, REG_DATA, {24'h00_0000, d});
    n0 = n_acc;
    slow <= 1'(xs() & 32'h1);
    keys(KEY_FIRST, KEY_SECOND);
    if (ok) check({31'h0, irq_hold, cpu_stall}, 33'h3, "stall");
    for (k = 0; k < 400 && cpu_stall !== 1'b0; k++) @(posedge pclk);
    check({32'h0, cpu_stall}, 33'h0, "stall end");
    check({32'h0, n_acc != n0}, {32'h0, ok}, "access");
    if (!ok) begin
      apb_rd(REG_STATUS, 33'h2, "refused");
      apb(1'b1, REG_STATUS, 32'h0000_0002);
    end
  endtask

  task automatic rd_flash(input logic [13:0] a, input logic [7:0] e);
    op(OP_READ, a, 8'h00, 1'b1);
    apb_rd(REG_DATA, {25'h0, e}, "flash byte");
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, result monitor
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end

  always @(posedge pclk) begin
    if (fl_ack === 1'b1) n_acc++;
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1, "unexpected read");
      else begin
        check({pslverr, prdata}, exp_q[0].val, exp_q[0].what);
        void'(exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int n0;
    seed = 32'h46ee_3afa;
    {psel, penable, pwrite, slow, presetn} = 5'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    opt_loader_pages = 3'h3;
    data_region_floor = 5'h1a;
    exec_in_loader = 1'b1;
    n_acc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb_rd(REG_STATUS, 33'h0, "status reset");
    apb_rd(8'h1c, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, REG_ADDR_HI, 32'h0000_00ff);
    apb_rd(REG_ADDR_HI, 33'h3f, "addr high");
    apb(1'b1, REG_CTRL, 32'h0000_0082);
    apb_rd(REG_CTRL, 33'h82, "ctrl");
    $display("test registers done");
    op(OP_ERASE, 14'h3400, 8'h00, 1'b1);
    rd_flash(14'h3412, 8'hff);
    op(OP_PROGRAM, 14'h3412, 8'ha5, 1'b1);
    rd_flash(14'h3412, 8'ha5);
    op(OP_PROGRAM, 14'h3412, 8'h5a, 1'b1);
    rd_flash(14'h3412, 8'h00);
    op(OP_PROGRAM, 14'h1000, 8'h0f, 1'b1);
    rd_flash(14'h1000, 8'h0c);
    $display("test loader done");
    exec_in_loader <= 1'b0;
    op(OP_PROGRAM, 14'h1000, 8'h00, 1'b0);
    rd_flash(14'h1000, 8'h0c);
    op(OP_PROGRAM, 14'h3420, 8'h3c, 1'b1);
    rd_flash(14'h3420, 8'h3c);
    op(OP_READ, 14'h3800, 8'h00, 1'b0);
    op(OP_STANDBY, 14'h3420, 8'h00, 1'b0);
    $display("test application done");
    apb(1'b1, REG_OPSEL, 32'h0000_0001);
    n0 = n_acc;
    keys(KEY_FIRST, 8'h12);
    keys(KEY_SECOND, KEY_SECOND);
    repeat (20) @(posedge pclk);
    check({32'h0, n_acc != n0}, 33'h0, "bad key access");
    apb_rd(REG_STATUS, 33'h0, "bad key status");
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    keys(KEY_FIRST, KEY_SECOND);
    repeat (20) @(posedge pclk);
    check({32'h0, n_acc != n0}, 33'h0, "disabled access");
    check({32'h0, cpu_stall}, 33'h0, "disabled stall");
    $display("test key discard done");
    apb(1'b1, REG_CTRL, {24'h00_0000, 8'h80 | 8'(xs() & 3)});
    op(OP_ERASE, 14'h3600, 8'h00, 1'b1);
    for (int i = 0; i < 512; i++) pg[i] = 8'hff;
    for (int i = 0; i < 6; i++) begin
      logic [8:0] off;
      logic [7:0] d;
      off = 9'(xs());
      d = 8'(xs());
      pg[off] = pg[off] & d;
      op(OP_PROGRAM, {5'h1b, off}, d, 1'b1);
      rd_flash({5'h1b, off}, pg[off]);
    end
    apb(1'b1, REG_OPSEL, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    apb_rd(REG_OPSEL, 33'h0, "standby");
    $display("test random done");
    tally_and_finish();
  end
endmodule // tb_top
